// file: logic/acc_config_bank.sv
// acc_config_bank: channel one configuration registers and field outputs.
// assumes a control port on clk giving address, write strobe, data.
// How it works
// - bit seven picks microphone or line input
// - bits six-five choose differential, single, stream
// - coupling bit matters only for analog sources
// - bits three-two choose input impedance
// - bit one reads zero, written zero
// - bit zero enables range processing block
// - gain code half-dB steps, max 84
// - sign bit negates gain, high impedance only
// - volume code, mute at zero, resets 201
// - trim code tenth-dB steps, resets eight
// - trim low nibble reads zero
`timescale 1ns/1ps
`include "acc_defs.svh"

module acc_config_bank
   import acc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   input wire logic range_processing_select_reg,
   output logic chan1_source_kind,
   output acc_source_t chan1_source_select,
   output logic chan1_coupling_select,
   output acc_impedance_t chan1_impedance_select,
   output logic chan1_range_processing_enable,
   output logic chan1_range_enhancer_en,
   output logic chan1_range_compressor_en,
   output logic [6:0] chan1_gain_code,
   output logic chan1_gain_negative,
   output logic [7:0] chan1_volume_code,
   output logic chan1_volume_mute,
   output logic [3:0] chan1_gain_trim_code,
   output logic chan1_analog_active,
   output logic chan1_config_legal
);

   // =========================================================
   // address decode
   wire logic sel_cfg = (reg_addr == `ACC_OFS_INPUT_CONFIG);
   wire logic sel_gain = (reg_addr == `ACC_OFS_ANALOG_GAIN);
   wire logic sel_vol = (reg_addr == `ACC_OFS_DIGITAL_VOLUME);
   wire logic sel_trim = (reg_addr == `ACC_OFS_GAIN_TRIM);
   assign reg_hit = sel_cfg | sel_gain | sel_vol | sel_trim;

   logic [7:0] chan1_input_config;
   logic [7:0] chan1_analog_gain;
   logic [7:0] chan1_digital_volume;
   logic [7:0] chan1_gain_trim;
   logic src_ok;
   logic gain_ok;

   // =========================================================
   // registers; cells only change on write or reset
   acc_reg_cell #(
      .reset_value(`ACC_RST_INPUT_CONFIG),
      .write_mask(`ACC_MASK_INPUT_CONFIG)
   ) u_input_config (
      .clk(clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .wr_en(reg_wr & sel_cfg),
      .wr_data(reg_wdata),
      .value(chan1_input_config)
   );

   acc_reg_cell #(
      .reset_value(`ACC_RST_ANALOG_GAIN),
      .write_mask(`ACC_MASK_ANALOG_GAIN)
   ) u_analog_gain (
      .clk(clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .wr_en(reg_wr & sel_gain),
      .wr_data(reg_wdata),
      .value(chan1_analog_gain)
   );

   acc_reg_cell #(
      .reset_value(`ACC_RST_DIGITAL_VOLUME),
      .write_mask(`ACC_MASK_DIGITAL_VOLUME)
   ) u_digital_volume (
      .clk(clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .wr_en(reg_wr & sel_vol),
      .wr_data(reg_wdata),
      .value(chan1_digital_volume)
   );

   acc_reg_cell #(
      .reset_value(`ACC_RST_GAIN_TRIM),
      .write_mask(`ACC_MASK_GAIN_TRIM)
   ) u_gain_trim (
      .clk(clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .wr_en(reg_wr & sel_trim),
      .wr_data(reg_wdata),
      .value(chan1_gain_trim)
   );

   // =========================================================
   // read mux; unmapped addresses read zero
   assign reg_rdata = sel_cfg ? chan1_input_config :
      sel_gain ? chan1_analog_gain :
      sel_vol ? chan1_digital_volume :
      sel_trim ? chan1_gain_trim : 8'h00;

   // =========================================================
   // field outputs
   assign chan1_source_kind =
      chan1_input_config[`ACC_BIT_SOURCE_KIND];
   assign chan1_range_processing_enable =
      chan1_input_config[`ACC_BIT_RANGE_EN];
   assign chan1_gain_code =
      chan1_analog_gain[`ACC_GAIN_HI:`ACC_GAIN_LO];
   assign chan1_gain_negative =
      chan1_analog_gain[`ACC_BIT_GAIN_NEG];
   assign chan1_volume_code = chan1_digital_volume;
   assign chan1_volume_mute =
      (chan1_digital_volume == `ACC_VOL_MUTE_CODE);
   assign chan1_gain_trim_code =
      chan1_gain_trim[`ACC_TRIM_HI:`ACC_TRIM_LO];
   // a stream source also needs pin routing that this bank cannot check
   assign chan1_config_legal = src_ok & gain_ok;

   acc_field_decode u_decode (
      .input_config(chan1_input_config),
      .analog_gain(chan1_analog_gain),
      .range_processing_select_reg(range_processing_select_reg),
      .chan1_source_select(chan1_source_select),
      .chan1_impedance_select(chan1_impedance_select),
      .chan1_coupling_select(chan1_coupling_select),
      .chan1_analog_active(chan1_analog_active),
      .chan1_source_legal(src_ok),
      .chan1_gain_legal(gain_ok),
      .chan1_range_enhancer_en(chan1_range_enhancer_en),
      .chan1_range_compressor_en(chan1_range_compressor_en)
   );

endmodule // acc_config_bank

// file: logic/acc_defs.svh
// acc_defs.svh: offsets, field positions, reset values of the channel one
// configuration registers. assumes inclusion by bare name only.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// =========================================================
// register offsets
`define ACC_OFS_INPUT_CONFIG 8'h3C
`define ACC_OFS_ANALOG_GAIN 8'h3D
`define ACC_OFS_DIGITAL_VOLUME 8'h3E
`define ACC_OFS_GAIN_TRIM 8'h3F

// =========================================================
// reset values
`define ACC_RST_INPUT_CONFIG 8'h00
`define ACC_RST_ANALOG_GAIN 8'h00
`define ACC_RST_DIGITAL_VOLUME 8'hC9
`define ACC_RST_GAIN_TRIM 8'h80

// =========================================================
// writable bit masks, read-only bits return zero
`define ACC_MASK_INPUT_CONFIG 8'hFD
`define ACC_MASK_ANALOG_GAIN 8'hFF
`define ACC_MASK_DIGITAL_VOLUME 8'hFF
`define ACC_MASK_GAIN_TRIM 8'hF0

// =========================================================
// field positions
`define ACC_BIT_SOURCE_KIND 7
`define ACC_SRC_HI 6
`define ACC_SRC_LO 5
`define ACC_BIT_COUPLING 4
`define ACC_IMP_HI 3
`define ACC_IMP_LO 2
`define ACC_BIT_RANGE_EN 0
`define ACC_GAIN_HI 7
`define ACC_GAIN_LO 1
`define ACC_BIT_GAIN_NEG 0
`define ACC_TRIM_HI 7
`define ACC_TRIM_LO 4

// =========================================================
// code limits
`define ACC_GAIN_MAX_CODE 7'h54
`define ACC_VOL_MUTE_CODE 8'h00
`define ACC_RANGE_SEL_BIT 3

`endif

// file: logic/acc_field_decode.sv
// acc_field_decode: derives datapath controls from the raw register bytes.
// assumes register bytes come from flip-flops on the same clock.
`timescale 1ns/1ps
`include "acc_defs.svh"

module acc_field_decode
   import acc_pkg::*;
(
   input wire logic [7:0] input_config,
   input wire logic [7:0] analog_gain,
   input wire logic range_processing_select_reg,
   output acc_source_t chan1_source_select,
   output acc_impedance_t chan1_impedance_select,
   output logic chan1_coupling_select,
   output logic chan1_analog_active,
   output logic chan1_source_legal,
   output logic chan1_gain_legal,
   output logic chan1_range_enhancer_en,
   output logic chan1_range_compressor_en
);

   // =========================================================
   // field extraction
   wire logic [1:0] src_raw =
      input_config[`ACC_SRC_HI:`ACC_SRC_LO];
   wire logic [1:0] imp_raw =
      input_config[`ACC_IMP_HI:`ACC_IMP_LO];
   wire logic range_on = input_config[`ACC_BIT_RANGE_EN];
   wire logic gain_neg = analog_gain[`ACC_BIT_GAIN_NEG];
   wire logic [6:0] gain_code =
      analog_gain[`ACC_GAIN_HI:`ACC_GAIN_LO];

   assign chan1_source_select = acc_source_t'(src_raw);
   assign chan1_impedance_select = acc_impedance_t'(imp_raw);
   assign chan1_source_legal = (src_raw != 2'h3) && (imp_raw != 2'h3);
   assign chan1_analog_active = (src_raw != 2'h2);
   // coupling ignored for the microphone stream source
   assign chan1_coupling_select =
      chan1_analog_active & input_config[`ACC_BIT_COUPLING];
   // negative gain only allowed at the higher impedances
   assign chan1_gain_legal = (gain_code <= `ACC_GAIN_MAX_CODE) &&
      (!gain_neg || imp_raw == 2'h1 || imp_raw == 2'h2);
   // select bit lives elsewhere; here it only steers the enable
   assign chan1_range_enhancer_en =
      range_on & ~range_processing_select_reg;
   assign chan1_range_compressor_en =
      range_on & range_processing_select_reg;

endmodule // acc_field_decode

// file: logic/acc_pkg.sv
// acc_pkg: enumerated field codes for the channel one config bank.
// assumes nothing of its surroundings.
package acc_pkg;

   // =========================================================
   // source select codes
   typedef enum logic [1:0] {
      acc_src_diff = 2'h0,
      acc_src_single = 2'h1,
      acc_src_mic_stream = 2'h2,
      acc_src_reserved = 2'h3
   } acc_source_t;

   // =========================================================
   // impedance codes
   typedef enum logic [1:0] {
      acc_imp_2k5 = 2'h0,
      acc_imp_10k = 2'h1,
      acc_imp_20k = 2'h2,
      acc_imp_reserved = 2'h3
   } acc_impedance_t;

endpackage

// file: logic/acc_reg_cell.sv
// acc_reg_cell: one 8-bit register with write mask and reset value.
// assumes write strobe and data on the same clock as the cell.
`timescale 1ns/1ps
`include "acc_defs.svh"

module acc_reg_cell
   import acc_pkg::*;
#(
   parameter logic [7:0] reset_value = 8'h00,
   parameter logic [7:0] write_mask = 8'hFF
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] value
);

   // =========================================================
   // storage
   // masked bits stay at their reset value, which is zero for reserved bits
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         value <= reset_value;
      else if (clk_en && wr_en)
         value <= (wr_data & write_mask) | (reset_value & ~write_mask);
   end

endmodule // acc_reg_cell

// file: verification/acc_config_bank_assertions.sv
// acc_config_bank_assertions: port checks of the channel one config bank.
// assumes binding into acc_config_bank, one clock, async low reset.
`timescale 1ns/1ps

module acc_config_bank_checker
   import acc_pkg::*;
(
   input logic clk,
   input logic rstn,
   input logic clk_en,
   input logic [7:0] reg_addr,
   input logic reg_wr,
   input logic [7:0] reg_wdata,
   input logic [7:0] reg_rdata,
   input logic reg_hit,
   input logic range_processing_select_reg,
   input acc_source_t chan1_source_select,
   input logic chan1_coupling_select,
   input logic chan1_range_processing_enable,
   input logic chan1_range_enhancer_en,
   input logic chan1_range_compressor_en,
   input logic [7:0] chan1_volume_code,
   input logic chan1_volume_mute
);
   // ====================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_unmapped; !reg_hit |-> reg_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read");
   property p_vol_wr;
      (reg_wr && clk_en && reg_addr == 8'h3E) |=>
         chan1_volume_code == $past(reg_wdata);
   endproperty
   a_vol_wr: assert property (p_vol_wr)
      else $error("volume write lost");
   property p_hold;
      !(reg_wr && clk_en) |=> $stable(chan1_volume_code);
   endproperty
   a_hold: assert property (p_hold) else $error("volume moved");
   property p_bit1; reg_addr == 8'h3C |-> !reg_rdata[1]; endproperty
   a_bit1: assert property (p_bit1) else $error("bit one set");
   property p_trim; reg_addr == 8'h3F |-> reg_rdata[3:0] == 4'h0; endproperty
   a_trim: assert property (p_trim) else $error("trim low nibble");
   property p_mute;
      chan1_volume_mute == (chan1_volume_code == 8'h00);
   endproperty
   a_mute: assert property (p_mute) else $error("mute flag");
   property p_rng;
      chan1_range_enhancer_en == (chan1_range_processing_enable &&
         !range_processing_select_reg) && chan1_range_compressor_en ==
         (chan1_range_processing_enable && range_processing_select_reg);
   endproperty
   a_rng: assert property (p_rng) else $error("range enables");
   property p_cpl;
      chan1_source_select == acc_src_mic_stream |-> !chan1_coupling_select;
   endproperty
   a_cpl: assert property (p_cpl) else $error("coupling on stream");
   property p_src;
      reg_addr == 8'h3C |-> reg_rdata[6:5] == chan1_source_select;
   endproperty
   a_src: assert property (p_src) else $error("source field");
   c_wr: cover property (reg_wr && clk_en && reg_hit);
   c_mute: cover property (chan1_volume_mute);
   c_stream: cover property (chan1_source_select == acc_src_mic_stream);
endmodule // acc_config_bank_checker

bind acc_config_bank acc_config_bank_checker u_chk (.clk, .rstn, .clk_en,
   .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .reg_hit,
   .range_processing_select_reg, .chan1_source_select, .chan1_coupling_select,
   .chan1_range_processing_enable, .chan1_range_enhancer_en,
   .chan1_range_compressor_en, .chan1_volume_code, .chan1_volume_mute);

// file: verification/testbench.sv
// testbench: writes and reads the config bank, checks read-back bytes.
// assumes the bank and its checker are compiled before this file.
`timescale 1ns/1ps

module testbench;
   logic clk = 0, rstn = 0, clk_en = 1, reg_wr = 0, sel = 0, rd_req = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_hit, legal, f_kind, f_active, f_neg;
   logic [1:0] f_imp;
   logic [6:0] f_gain;
   logic [3:0] f_trim;
   wire logic [15:0] fld_seen = {f_kind, f_imp, f_active, f_gain, f_neg,
      f_trim};
   logic [7:0] mdl [4];
   logic [25:0] exp_q [$];
   logic [25:0] e;
   logic [31:0] seed = 32'h7BE8, r;
   int err_total = 0, checks = 0;
   localparam logic [7:0] MSK [4] = '{8'hFD, 8'hFF, 8'hFF, 8'hF0};
   localparam logic [6:0] GN [5] = '{7'h00, 7'h01, 7'h54, 7'h55, 7'h7F};
   localparam logic [7:0] VL [4] = '{8'h00, 8'h01, 8'hC9, 8'hFF};

   acc_config_bank DUT (.clk, .rstn, .clk_en, .reg_addr, .reg_wr, .reg_wdata,
      .reg_rdata, .reg_hit, .range_processing_select_reg(sel),
      .chan1_source_kind(f_kind), .chan1_source_select(),
      .chan1_coupling_select(), .chan1_impedance_select(f_imp),
      .chan1_range_processing_enable(), .chan1_range_enhancer_en(),
      .chan1_range_compressor_en(), .chan1_gain_code(f_gain),
      .chan1_gain_negative(f_neg), .chan1_volume_code(),
      .chan1_volume_mute(), .chan1_gain_trim_code(f_trim),
      .chan1_analog_active(f_active), .chan1_config_legal(legal));

   initial forever #2 clk = ~clk;

   // ====================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // stored reserved codes stay legal to write, only the flag drops
   function automatic logic lgl();
      logic [1:0] imp;
      imp = mdl[0][3:2];
      return mdl[0][6:5] != 2'h3 && imp != 2'h3 && mdl[1][7:1] <= 7'h54
         && (!mdl[1][0] || imp == 2'h1 || imp == 2'h2);
   endfunction

   // field outputs follow the stored bytes; a stream source is not analog
   function automatic logic [15:0] fld();
      return {mdl[0][7], mdl[0][3:2], mdl[0][6:5] != 2'h2, mdl[1],
         mdl[3][7:4]};
   endfunction

   task automatic wr(input logic [7:0] a, d, input logic en = 1'h1);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      clk_en <= en;
      sel <= ^rnd();
      if (en && a[7:2] == 6'h0F)
         mdl[a[1:0]] = d & MSK[a[1:0]];
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a);
      logic hit;
      hit = a[7:2] == 6'h0F;
      @(posedge clk);
      reg_addr <= a;
      rd_req <= 1'h1;
      exp_q.push_back({fld(), lgl(), hit, hit ? mdl[a[1:0]] : 8'h00});
      @(posedge clk);
      rd_req <= 1'h0;
   endtask

   task automatic print_verdict();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // read data is combinational, so it is settled by the falling edge
   always @(negedge clk)
   begin
      if (rd_req)
      begin
         e = exp_q.pop_front();
         checks++;
         if ({legal, reg_hit, reg_rdata} !== e[9:0])
         begin
            err_total++;
            $display("unexpected legal_hit_rdata exp %h got %h", e[9:0],
               {legal, reg_hit, reg_rdata});
         end
         checks++;
         if (fld_seen !== e[25:10])
         begin
            err_total++;
            $display("unexpected fields exp %h got %h", e[25:10],
               fld_seen);
         end
      end
   end

   // ====================
   // scenarios
   initial
   begin
      mdl = '{8'h00, 8'h00, 8'hC9, 8'h80};
      repeat (20) @(posedge clk);
      rstn <= 1'h1;
      for (int a = 8'h3B; a <= 8'h40; a++)
         rd(8'(a));
      for (int i = 0; i < 16; i++)
      begin
         r = rnd();
         wr(8'h3C, {r[7], i[1:0], r[4], i[3:2], 1'h1, r[0]});
         rd(8'h3C);
      end
      for (int j = 0; j < 15; j++)
      begin
         wr(8'h3C, {4'h0, 2'(j % 3), 2'h0});
         wr(8'h3D, {GN[j / 3], j[0]});
         rd(8'h3D);
      end
      foreach (VL[k])
      begin
         wr(8'h3E, VL[k]);
         wr(8'h3F, VL[k]);
         rd(8'h3E);
         rd(8'h3F);
      end
      wr(8'h3E, 8'h5A, 1'h0);
      wr(8'h40, 8'h5A);
      rd(8'h3E);
      repeat (40)
      begin
         r = rnd();
         wr({6'h0F, r[9:8]}, r[7:0]);
         rd({6'h0F, r[11:10]});
      end
      wr(8'h3E, 8'h11);
      @(posedge clk);
      rstn <= 1'h0;
      mdl = '{8'h00, 8'h00, 8'hC9, 8'h80};
      repeat (3) @(posedge clk);
      rstn <= 1'h1;
      rd(8'h3E);
      rd(8'h3F);
      print_verdict();
   end

   initial
   begin
      repeat (100000) @(posedge clk);
      err_total++;
      print_verdict();
   end
endmodule // testbench
